// ---- rtl/reset_source_and_init_ctrl.sv ----
// Reset sources, power-on flag, register initialisation and wake-up vectoring
// Notes on behaviour
// - Device enters reset while the enabled external reset pin is held low.
// - External reset input is filtered; short low glitches are ignored.
// - Internal resets never drive the external reset pin low.
// - With pin reset disabled, the pin is a plain digital input.
// - Power-on event generates an internal reset pulse.
// - Every power-on reset clears the active-low power-on flag bit 1.
// - Power-on flag holds across all resets except power-on and brown-out.
// - Only software sets the power-on flag back to one.
// - Brown-out initialises like power-on; other resets form a second class.
// - Interrupt wake-up with a global enable pushes PC and advances stack index.
// - Interrupt wake-up then loads the high or low priority vector.
// - Wake-up comes with a flag set in an interrupt flag register.
// - Port A bit 6 reads zero when the oscillator claims that pin.
// - Timer0 control initialises to all ones on reset, holds on wake-up.
// - Timer2 period initialises to all ones on reset and wake-up.
// - Timer2 count and timer0 high buffer clear on reset, hold on wake-up.
// - Timer1 control clears on power-on; other resets clear only bit 6.
// - Serial address, status, both controls clear on reset, hold on wake-up.
// - Data registers undefined at power-on, kept through other resets.
// - Oscillator control initialises to bit 6 set plus a condition bit.
// - Voltage-detect control initialises to its pattern, bit 6 reads zero.
`timescale 1ns/1ps
`include "reset_init_regs.svh"

module reset_source_and_init_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic extResetNPin,
  input wire logic extResetPinEnable,
  input wire logic porPulse,
  input wire logic borPulse,
  input wire reset_init_pkg::int_reset_t intReset,
  input wire logic porFlagSetSw,
  input wire logic oscClaimsRa6,
  input wire logic [7:0] portAIn,
  input wire logic sleepReq,
  input wire logic wakeIrq,
  input wire logic wakeIrqHigh,
  input wire logic [7:0] wakeFlagMask,
  input wire logic globalIrqEnableHigh,
  input wire logic globalIrqEnableLow,
  input wire logic [20:0] pc,
  input wire logic [7:0] t1ControlWr,
  input wire logic t1ControlWe,
  input wire logic [7:0] dataIn,
  input wire logic dataWe,
  output logic extResetNPinOut,
  output logic extResetNPinOe,
  output logic extPinDigital,
  output logic coreReset,
  output logic porFlagN,
  output logic [7:0] portAPins,
  output logic [7:0] periphIrqFlagRegs,
  output logic [20:0] topOfStack,
  output logic [4:0] returnStackIndex,
  output logic [20:0] pcLoad,
  output logic pcLoadValid,
  output logic asleep,
  output reset_init_pkg::init_regs_t initRegs,
  output reset_init_pkg::data_regs_t dataRegs
);
  import reset_init_pkg::*;

  logic rstSync1;
  logic rstSync2;
  logic pinMeta;
  logic pinSync;
  logic porMeta;
  logic porSync;
  logic borMeta;
  logic borSync;
  logic [3:0] lowCount;
  logic pinResetReq;
  logic porEvent;
  logic otherEvent;
  logic pendPor;
  logic pendOther;
  logic resetPending;
  logic wakeArmed;
  core_state_t state;
  core_state_t next_state;

  // Release of the module reset through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // Reset pin synchroniser; idles high so release shows no false low
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= extResetNPin;
      pinSync <= pinMeta;
    end
  end

  // Power-on detector pulse, asynchronous to the core clock
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      porMeta <= 1'b0;
      porSync <= 1'b0;
    end else begin
      porMeta <= porPulse;
      porSync <= porMeta;
    end
  end

  // Brown-out detector pulse, same two-flop treatment
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      borMeta <= 1'b0;
      borSync <= 1'b0;
    end else begin
      borMeta <= borPulse;
      borSync <= borMeta;
    end
  end

  // Glitch filter: low must persist for the filter time
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      lowCount <= 4'h0;
    end else if (pinSync || !extResetPinEnable) begin
      lowCount <= 4'h0;
    end else if (lowCount != 4'(`FILTER_CYC)) begin
      lowCount <= lowCount + 4'h1;
    end
  end

  assign pinResetReq = extResetPinEnable && (lowCount == 4'(`FILTER_CYC));
  // Brown-out sits in the power-on class
  assign porEvent = porSync || borSync;
  assign otherEvent = pinResetReq || intReset.wdtTimeout || intReset.resetInstr
    || intReset.stackFault;

  // Pending power-on class, applied next cycle so all registers move together
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      pendPor <= 1'b1;
    end else begin
      pendPor <= porEvent;
    end
  end

  // Pending second class; power-on class wins when both arrive together
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      pendOther <= 1'b0;
    end else begin
      pendOther <= otherEvent && !porEvent;
    end
  end

  // Core reset level, registered so every consumer leaves reset on one edge
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= porEvent || otherEvent;
    end
  end

  // Either class pending holds the sequencer and loads initial values
  assign resetPending = pendPor || pendOther;

  // Pin is input only; internal sources never pull it
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      extResetNPinOut <= 1'b1;
      extResetNPinOe <= 1'b0;
    end else begin
      extResetNPinOut <= 1'b1;
      extResetNPinOe <= 1'b0;
    end
  end

  // Digital view of the pin, only meaningful with pin reset disabled
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      extPinDigital <= 1'b1;
    end else begin
      extPinDigital <= extResetPinEnable ? 1'b1 : pinSync;
    end
  end

  // Power-on flag: hardware only clears it; software sets it, and a power-on class clear wins over the set
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      porFlagN <= 1'b0;
    end else if (pendPor) begin
      porFlagN <= 1'b0;
    end else if (porFlagSetSw && !porEvent) begin
      porFlagN <= 1'b1;
    end
    // Other resets leave it alone
  end

  // Port A view with oscillator-owned bit forced low
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      portAPins <= `INIT_ZERO;
    end else begin
      portAPins <= portAIn;
      if (oscClaimsRa6) begin
        portAPins[`PORT_A_PINS_RA6_BIT] <= 1'b0;
      end
    end
  end

  // Either global enable arms the push and vector steps
  assign wakeArmed = globalIrqEnableHigh || globalIrqEnableLow;

  // Sleep and wake sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      RUN: begin
        if (sleepReq) begin
          next_state = SLEEP;
        end
      end
      SLEEP: begin
        if (wakeIrq) begin
          next_state = wakeArmed ? WAKE_PUSH : RUN;
        end
      end
      WAKE_PUSH: begin
        next_state = WAKE_VEC;
      end
      WAKE_VEC: begin
        next_state = RUN;
      end
    endcase
  end

  // Any reset drops the sequencer back to run
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      state <= RUN;
    end else if (resetPending) begin
      state <= RUN;
    end else begin
      state <= next_state;
    end
  end

  // Registered sleep indication follows the next state
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      asleep <= 1'b0;
    end else begin
      asleep <= (next_state == SLEEP) && !resetPending;
    end
  end

  // Stack push on interrupt wake-up; index saturates instead of wrapping
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      topOfStack <= 21'h000000;
      returnStackIndex <= 5'h00;
    end else if (resetPending) begin
      returnStackIndex <= 5'h00;
    end else if (state == WAKE_PUSH) begin
      topOfStack <= pc;
      if (returnStackIndex != `STK_MAX) begin
        returnStackIndex <= returnStackIndex + 5'h01;
      end
    end
  end

  // Vector load one step after the push, valid for a single cycle
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      pcLoad <= 21'h000000;
      pcLoadValid <= 1'b0;
    end else if (resetPending) begin
      pcLoadValid <= 1'b0;
    end else begin
      pcLoadValid <= (state == WAKE_VEC);
      if (state == WAKE_VEC) begin
        pcLoad <= wakeIrqHigh ? `VEC_HIGH : `VEC_LOW;
      end
    end
  end

  // Waking source flag; a pending reset clears it and wins over the set
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      periphIrqFlagRegs <= `INIT_ZERO;
    end else if (pendPor || pendOther) begin
      periphIrqFlagRegs <= `INIT_ZERO;
    end else if (state == SLEEP && wakeIrq) begin
      periphIrqFlagRegs <= periphIrqFlagRegs | wakeFlagMask | 8'h01;
    end
  end

  // Control register initial values per reset class
  always_ff @(posedge mclk or negedge rstSync2) begin
    if (!rstSync2) begin
      initRegs <= '0;
    end else if (pendPor || pendOther) begin
      initRegs.timer0Control <= `INIT_ONES;
      initRegs.timer0HighBuffer <= `INIT_ZERO;
      initRegs.timer2Count <= `INIT_ZERO;
      initRegs.timer2Period <= `INIT_ONES;
      initRegs.syncSerialAddr <= `INIT_ZERO;
      initRegs.syncSerialStatus <= `INIT_ZERO;
      initRegs.syncSerialCtrl1 <= `INIT_ZERO;
      initRegs.syncSerialCtrl2 <= `INIT_ZERO;
      initRegs.voltageDetectControl <= `INIT_VDET & `VDET_UNIMP_MASK;
      initRegs.oscControl <= pendPor ? `INIT_OSC_POR : `INIT_OSC_OTH;
      if (pendPor) begin
        initRegs.oscControl[`OSC_POR_QBIT] <= oscClaimsRa6;
        initRegs.timer1Control <= `INIT_ZERO;
      end else begin
        initRegs.oscControl[`OSC_OTH_QBIT] <= oscClaimsRa6;
        initRegs.timer1Control[`T1_KEEP_CLR_BIT] <= 1'b0;
      end
    end else begin
      if (state == WAKE_VEC || (state == SLEEP && wakeIrq)) begin
        initRegs.timer2Period <= `INIT_ONES;
      end
      if (t1ControlWe) begin
        initRegs.timer1Control <= t1ControlWr;
      end
    end
  end

  // Data registers: no init on any reset; power-on value is arbitrary
  always_ff @(posedge mclk) begin
    if (dataWe && !(pendPor || pendOther)) begin
      dataRegs <= {4{dataIn}};
    end
  end
endmodule

// ---- rtl/reset_init_regs.svh ----
// Constants for the reset source and register initialisation controller
`ifndef RESET_INIT_REGS_SVH
`define RESET_INIT_REGS_SVH

`define FILTER_NS 200
`define CLK_NS 40
`define FILTER_CYC ((`FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define POR_FLAG_BIT 1
`define PORT_A_PINS_RA6_BIT 6
`define T1_KEEP_CLR_BIT 6
`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define INIT_ONES 8'hff
`define INIT_ZERO 8'h00
`define INIT_OSC_POR 8'h40
`define INIT_OSC_OTH 8'h40
`define OSC_POR_QBIT 3
`define OSC_OTH_QBIT 1
`define INIT_VDET 8'h05
`define VDET_UNIMP_MASK 8'hbf
`define STK_MAX 5'h1f

`endif

// ---- rtl/reset_init_pkg.sv ----
// Types shared by the reset controller
package reset_init_pkg;
  typedef enum logic [1:0] {
    RUN = 2'b00,
    SLEEP = 2'b01,
    WAKE_PUSH = 2'b11,
    WAKE_VEC = 2'b10
  } core_state_t;

  typedef struct packed {
    logic [7:0] timer0Control;
    logic [7:0] timer0HighBuffer;
    logic [7:0] timer1Control;
    logic [7:0] timer2Count;
    logic [7:0] timer2Period;
    logic [7:0] syncSerialAddr;
    logic [7:0] syncSerialStatus;
    logic [7:0] syncSerialCtrl1;
    logic [7:0] syncSerialCtrl2;
    logic [7:0] oscControl;
    logic [7:0] voltageDetectControl;
  } init_regs_t;

  typedef struct packed {
    logic [7:0] timer0LowCount;
    logic [7:0] timer1HighCount;
    logic [7:0] syncSerialBuffer;
    logic [7:0] converterResultHigh;
  } data_regs_t;

  typedef struct packed {
    logic wdtTimeout;
    logic resetInstr;
    logic stackFault;
  } int_reset_t;
endpackage

// ---- verif/ext_reset_circuit.sv ----
// Behavioural reset supervisor that pulls the reset pin low on command
`timescale 1ns/1ps
module ext_reset_circuit (
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] lowLen,
  output logic extResetNPin
);
  logic [3:0] left = 4'h0;
  // Count down the low time; pull-up returns the pin high between presses
  always_ff @(posedge mclk) begin
    if (go)
      left <= lowLen;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign extResetNPin = (left == 4'h0);
endmodule

// ---- verif/reset_source_and_init_ctrl_props.sv ----
// Port checks for the reset controller
`timescale 1ns/1ps
module reset_source_and_init_ctrl_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic extResetNPin,
  input wire logic extResetPinEnable,
  input wire logic porPulse,
  input wire logic porFlagSetSw,
  input wire logic wakeIrq,
  input wire logic wakeIrqHigh,
  input wire logic globalIrqEnableHigh,
  input wire logic globalIrqEnableLow,
  input wire logic extResetNPinOut,
  input wire logic extResetNPinOe,
  input wire logic extPinDigital,
  input wire logic coreReset,
  input wire logic porFlagN,
  input wire logic [7:0] periphIrqFlagRegs,
  input wire logic [20:0] pcLoad,
  input wire logic pcLoadValid,
  input wire logic asleep
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Wake steps: armed interrupt in sleep, then the vector load
  sequence armedWake;
    asleep && wakeIrq && (globalIrqEnableHigh || globalIrqEnableLow);
  endsequence
  sequence vectorLoad;
    pcLoadValid && pcLoad == (wakeIrqHigh ? 21'h000008 : 21'h000018);
  endsequence
  AST_PIN_INPUT_ONLY: assert property (!extResetNPinOe && extResetNPinOut)
    else $error("reset pin driven");
  AST_PIN_RESET: assert property ((extResetPinEnable && !extResetNPin) [*8]
    |-> ##[0:3] coreReset) else $error("held pin gave no reset");
  AST_PIN_DIGITAL: assert property ((!extResetPinEnable && $stable(extResetNPin)) [*5]
    |-> extPinDigital == extResetNPin) else $error("digital pin level wrong");
  AST_POR_CLEARS: assert property ($rose(porPulse) |-> ##[1:8] !porFlagN)
    else $error("power-on flag not cleared");
  AST_FLAG_SW_ONLY: assert property ($rose(porFlagN) |-> $past(porFlagSetSw) ||
    $past(porFlagSetSw, 2) || $past(porFlagSetSw, 3)) else $error("flag set by hardware");
  AST_WAKE_VECTOR: assert property (armedWake |-> ##[1:5] vectorLoad)
    else $error("wake vector missing");
  AST_NO_VECTOR: assert property (asleep && wakeIrq && !globalIrqEnableHigh &&
    !globalIrqEnableLow |-> (!pcLoadValid) [*5]) else $error("vector without enable");
  AST_WAKE_FLAG: assert property (asleep && wakeIrq |-> ##[1:3] periphIrqFlagRegs != 8'h00)
    else $error("wake without flag");
endmodule

bind reset_source_and_init_ctrl reset_source_and_init_ctrl_props props (.mclk, .nrst,
  .extResetNPin, .extResetPinEnable, .porPulse, .porFlagSetSw, .wakeIrq, .wakeIrqHigh,
  .globalIrqEnableHigh, .globalIrqEnableLow, .extResetNPinOut, .extResetNPinOe,
  .extPinDigital, .coreReset, .porFlagN, .periphIrqFlagRegs, .pcLoad, .pcLoadValid, .asleep);

// ---- verif/reset_source_and_init_ctrl_test.sv ----
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module reset_source_and_init_ctrl_test;
  import reset_init_pkg::*;
  logic mclk, nrst, extResetPinEnable, porPulse, borPulse, porFlagSetSw, oscClaimsRa6, go;
  logic sleepReq, wakeIrq, wakeIrqHigh, globalIrqEnableHigh, globalIrqEnableLow, dataWe;
  logic t1ControlWe, extResetNPin, extResetNPinOut, extResetNPinOe, extPinDigital, seen;
  logic coreReset, porFlagN, pcLoadValid, asleep;
  logic [3:0] lowLen;
  logic [7:0] portAIn, t1ControlWr, dataIn, wakeFlagMask, portAPins, periphIrqFlagRegs;
  logic [20:0] pc, topOfStack, pcLoad;
  logic [4:0] returnStackIndex;
  int_reset_t intReset;
  init_regs_t initRegs;
  data_regs_t dataRegs;
  int errors = 0, compares = 0, seed = 32'hff98, modelT1, modelData, modelIdx, k, i;
  // Supervisor on the pin and the unit under test
  ext_reset_circuit sup (.mclk, .go, .lowLen, .extResetNPin);
  reset_source_and_init_ctrl uut (.mclk, .nrst, .extResetNPin, .extResetPinEnable, .porPulse,
    .borPulse, .intReset, .porFlagSetSw, .oscClaimsRa6, .portAIn, .sleepReq, .wakeIrq,
    .wakeIrqHigh, .wakeFlagMask, .globalIrqEnableHigh, .globalIrqEnableLow, .pc, .t1ControlWr,
    .t1ControlWe, .dataIn, .dataWe, .extResetNPinOut, .extResetNPinOe, .extPinDigital,
    .coreReset, .porFlagN, .portAPins, .periphIrqFlagRegs, .topOfStack, .returnStackIndex,
    .pcLoad, .pcLoadValid, .asleep, .initRegs, .dataRegs);
  always #20 mclk = ~mclk;
  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
    compares++;
    if (got !== want) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Note any reset, then wait, bounded, for the core to run again
  task automatic settle;
    seen = 1'b0;
    for (i = 0; i < 60 && (i < 16 || coreReset !== 1'b0); i++) begin
      @(negedge mclk);
      if (coreReset === 1'b1) seen = 1'b1;
    end
    repeat (3) @(negedge mclk);
  endtask
  // Fresh random contents before each reset, so kept values are visible
  task automatic loadRegs;
    modelT1 = $random(seed) & 'hff;
    modelData = $random(seed) & 'hff;
    @(posedge mclk);
    {t1ControlWr, dataIn, t1ControlWe, dataWe} <= {modelT1[7:0], modelData[7:0], 2'b11};
    @(posedge mclk);
    {t1ControlWe, dataWe} <= 2'b00;
  endtask
  task automatic chkInit(input logic porClass);
    chk("t0Ctl", 8'hff, initRegs.timer0Control);
    chk("t0HbT2Cnt", 16'h0000, {initRegs.timer0HighBuffer, initRegs.timer2Count});
    chk("t2Period", 8'hff, initRegs.timer2Period);
    chk("serial", 32'h0, initRegs[47:16]);
    chk("osc", porClass ? {4'h4, oscClaimsRa6, 3'h0} : {6'h10, oscClaimsRa6, 1'b0}, initRegs.oscControl);
    chk("vdet", 8'h05, initRegs.voltageDetectControl);
    chk("t1Ctl", porClass ? 8'h00 : modelT1[7:0] & 8'hbf, initRegs.timer1Control);
  endtask
  task tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  // Main sequence: power-up, every reset source, pin filter, port A, wake-up
  initial begin
    {mclk, nrst, porPulse, borPulse, porFlagSetSw, oscClaimsRa6, go, sleepReq, wakeIrq} = '0;
    {wakeIrqHigh, globalIrqEnableHigh, globalIrqEnableLow, dataWe, t1ControlWe, intReset} = '0;
    {portAIn, t1ControlWr, dataIn, wakeFlagMask, pc} = '0;
    extResetPinEnable = 1'b1;
    lowLen = 4'hc;
    tick(5);
    nrst <= 1'b1;
    settle;
    chkInit(1'b1);
    chk("porFlagN", 1'b0, porFlagN);
    chk("pinDrive", 2'b01, {extResetNPinOe, extResetNPinOut});
    @(posedge mclk) porFlagSetSw <= 1'b1;
    @(posedge mclk) porFlagSetSw <= 1'b0;
    settle;
    chk("porFlagN", 1'b1, porFlagN);
    for (k = 0; k < 6; k++) begin
      loadRegs;
      @(posedge mclk);
      oscClaimsRa6 <= k[0];
      go <= (k == 0);
      intReset <= (k inside {[1:3]}) ? 3'b100 >> (k - 1) : 3'b000;
      {borPulse, porPulse} <= (k == 4) ? 2'b10 : (k == 5) ? 2'b01 : 2'b00;
      tick(3);
      {go, intReset, borPulse, porPulse} <= '0;
      settle;
      chk("seen", 1'b1, seen);
      chkInit(k > 3);
      if (k != 4) chk("porFlagN", k < 5, porFlagN);
      if (k < 4) chk("data", {4{modelData[7:0]}}, dataRegs);
    end
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      extResetPinEnable <= !k[0];
      lowLen <= k[0] ? 4'hc : 4'h4;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      tick(6);
      @(negedge mclk) chk("digital", !k[0], extPinDigital);
      settle;
      chk("seen", 1'b0, seen);
    end
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      oscClaimsRa6 <= k[0];
      portAIn <= $random(seed);
      tick(3);
      @(negedge mclk) chk("port_a_pins", k ? portAIn & 8'hbf : portAIn, portAPins);
    end
    modelIdx = 0;
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      {sleepReq, globalIrqEnableHigh, globalIrqEnableLow, wakeIrqHigh} <= {1'b1, k == 1, k == 2, k == 1};
      wakeFlagMask <= 8'h04;
      pc <= 21'($random(seed)) & 21'h1ffffe;
      @(posedge mclk);
      sleepReq <= 1'b0;
      tick(2);
      @(negedge mclk) chk("asleep", 1'b1, asleep);
      @(posedge mclk) wakeIrq <= 1'b1;
      @(posedge mclk) wakeIrq <= 1'b0;
      seen = 1'b0;
      repeat (6) @(negedge mclk) if (pcLoadValid === 1'b1) begin
        seen = 1'b1;
        chk("vector", (k == 1) ? 21'h000008 : 21'h000018, pcLoad);
      end
      chk("vectorSeen", k != 0, seen);
      modelIdx += (k != 0);
      if (k != 0) chk("push", {modelIdx[4:0], pc}, {returnStackIndex, topOfStack});
      chk("wakeFlag", 1'b1, |periphIrqFlagRegs);
      chk("t2Period", 8'hff, initRegs.timer2Period);
    end
    tally_and_finish;
  end
endmodule
